// ---- dv/eimv_evt_model.sv ----
// Event unit stand-in: flag and mask levels for the vector block.
// Assumes the bench sets the wanted levels; they land one edge later.
module eimv_evt_model import eimv_pkg::*; (
    input wire logic core_clk,
    input wire logic [67:0] want,
    output logic [EIMV_GRP_W-1:0] flag_group_a,
    output logic [EIMV_GRP_W-1:0] flag_group_b,
    output logic [EIMV_CAP_W-1:0] flag_group_c,
    output logic [EIMV_GRP_W-1:0] mask_group_a,
    output logic [EIMV_GRP_W-1:0] mask_group_b
);
    timeunit 1ns;
    timeprecision 1ns;
    // Registered, as the flag registers are
    always_ff @(posedge core_clk) begin
        {flag_group_a, flag_group_b, flag_group_c, mask_group_a, mask_group_b} <= want;
    end
endmodule : eimv_evt_model

// ---- dv/tb_top.sv ----
// Self-checking bench: APB master, random flags, vector and irq checks.
// Assumes vector registers are consecutive indices and the mapped id tables.
module tb_top import eimv_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic [EIMV_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, cm;
    logic [3:0] pstrb = '0, cap_en, fc;
    logic [15:0] fa, fb, ma, mb;
    logic [67:0] want = '0;
    int err_total = 0, check_count = 0, seed = 25;
    always #50 core_clk = ~core_clk;
    // ==========================================================
    // Id tables: group base plus bit index, lowest bit wins
    function automatic logic [95:0] tab(input int base);
        for (int i = 0; i < 16; i++) tab[6*i+:6] = 6'(base + i);
    endfunction : tab
    function automatic logic [31:0] vec(input logic [15:0] p, input int base);
        vec = 0;
        for (int i = 15; i >= 0; i--) if (p[i]) vec = 32'(base + i);
    endfunction : vec
    eimv_evt_model evt (.core_clk(core_clk), .want(want), .flag_group_a(fa), .flag_group_b(fb),
        .flag_group_c(fc), .mask_group_a(ma), .mask_group_b(mb));
    eimv_top #(.ID_TABLE_A(tab(1)), .ID_TABLE_B(tab(17)), .ID_TABLE_C(tab(33))) DUT (.core_clk(core_clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flag_group_a(fa),
        .flag_group_b(fb), .flag_group_c(fc), .mask_group_a(ma), .mask_group_b(mb),
        .capture_irq_enable(cap_en), .irq(irq));
    // ==========================================================
    // Bus and compare tasks
    // No wait limit of its own: a hung slave is caught by the watchdog
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd, input logic [3:0] st = 4'hf);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= wd; pstrb <= st;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
        @(posedge core_clk);
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic print_verdict();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1;
        @(posedge core_clk);
        for (int g = 0; g < 3; g++) begin apb(0, EIMV_IDX_VECTOR_GROUP_A + 16'(g), 0); chk("vec_rst", rd, 0); end
        apb(0, EIMV_IDX_CAPTURE_IRQ_MASK, 0); chk("cap_rst", rd, 0);
        apb(1, EIMV_IDX_CAPTURE_IRQ_MASK, '1); apb(0, EIMV_IDX_CAPTURE_IRQ_MASK, 0); chk("cap_hi", rd, 32'hf);
        chk("cap_en", 32'(cap_en), 32'hf);
        // Lane 0 strobe low: the write must be dropped
        apb(1, EIMV_IDX_CAPTURE_IRQ_MASK, 0, 4'h0); apb(0, EIMV_IDX_CAPTURE_IRQ_MASK, 0); chk("cap_strb", rd, 32'hf);
        apb(1, EIMV_IDX_VECTOR_GROUP_A, '1); apb(0, EIMV_IDX_VECTOR_GROUP_A, 0); chk("vec_ro", rd, 0);
        apb(0, 16'h7400, 0); chk("unmapped", {rd[30:0], err}, 1);
        // Corner cases first: nothing pending, then everything pending
        for (int k = 0; k < 24; k++) begin
            want <= k == 0 ? '0 : k == 1 ? '1 : 68'({$random(seed), $random(seed), $random(seed)});
            cm = k == 1 ? '1 : $random(seed);
            apb(1, EIMV_IDX_CAPTURE_IRQ_MASK, cm);
            repeat (2) @(posedge core_clk);
            apb(0, EIMV_IDX_VECTOR_GROUP_A, 0); chk("vec_a", rd, vec(fa & ma, 1));
            apb(0, EIMV_IDX_VECTOR_GROUP_B, 0); chk("vec_b", rd, vec(fb & mb, 17));
            apb(0, EIMV_IDX_VECTOR_GROUP_C, 0); chk("vec_c", rd, vec({12'h0, fc & cm[3:0]}, 33));
            chk("cap_en", 32'(cap_en), {28'h0, cm[3:0]});
        end
        chk("irq_masked", 32'(irq), 0);
        want <= {16'h0001, 16'h0000, 4'h0, 16'h0001, 16'h0000};
        apb(1, EIMV_IDX_IRQ_MASK, 1);
        repeat (4) @(posedge core_clk);
        chk("irq_on", 32'(irq), 1);
        apb(1, EIMV_IDX_IRQ_MASK, 0);
        chk("irq_off", 32'(irq), 0);
        want <= '0;
        repeat (3) @(posedge core_clk);
        apb(1, EIMV_IDX_IRQ_STATUS, 7); apb(0, EIMV_IDX_IRQ_STATUS, 0); chk("irq_clr", rd, 0);
        print_verdict();
    end
    initial begin
        #(100 * 20000);
        err_total++;
        print_verdict();
    end
endmodule : tb_top

// ---- verilog/eimv_pkg.sv ----
// Package for the event interrupt mask and vector block.
// Assumes an APB master with 32-bit data; registers sit in the low 16 bits.
package eimv_pkg;
    // ==========================================================
    // Register indices (printed offsets are word indices)
    localparam logic [15:0] EIMV_IDX_CAPTURE_IRQ_MASK = 16'h742e;
    localparam logic [15:0] EIMV_IDX_VECTOR_GROUP_A = 16'h7432;
    localparam logic [15:0] EIMV_IDX_VECTOR_GROUP_B = 16'h7433;
    localparam logic [15:0] EIMV_IDX_VECTOR_GROUP_C = 16'h7434;
    localparam logic [15:0] EIMV_IDX_IRQ_STATUS = 16'h7440;
    localparam logic [15:0] EIMV_IDX_IRQ_MASK = 16'h7441;
    // ==========================================================
    // Field layout
    localparam int EIMV_ADDR_W = 18;
    localparam int EIMV_CAP_W = 4;
    localparam int EIMV_VEC_W = 6;
    localparam int EIMV_GRP_W = 16;
    localparam int EIMV_NGRP = 3;
    localparam logic [3:0] EIMV_CAP_MASK_RST = 4'h0;
    localparam logic [5:0] EIMV_VEC_NONE = 6'h00;
    localparam logic [2:0] EIMV_IRQ_RST = 3'h0;
    localparam logic [31:0] EIMV_ZERO_WORD = 32'h0000_0000;
    function automatic logic [EIMV_ADDR_W-1:0] eimv_byte_addr(input logic [15:0] idx);
        eimv_byte_addr = {idx, 2'b00};
    endfunction : eimv_byte_addr
endpackage : eimv_pkg

// ---- verilog/eimv_prio.sv ----
// Priority encoder: lowest set bit wins, its id from the fixed table.
// Assumes the table inputs are constant wiring from the event unit.
module eimv_prio import eimv_pkg::*; #(
    parameter int N = EIMV_GRP_W
) (
    input wire logic [N-1:0] pending,
    input wire logic [N*EIMV_VEC_W-1:0] id_table,
    output logic [EIMV_VEC_W-1:0] vector_id
);
    always_comb begin
        vector_id = EIMV_VEC_NONE;
        for (int i = N - 1; i >= 0; i--) begin
            if (pending[i]) begin
                vector_id = id_table[i*EIMV_VEC_W +: EIMV_VEC_W];
            end
        end
    end
endmodule : eimv_prio

// ---- verilog/eimv_top.sv ----
// Capture interrupt mask and three vector registers behind APB.
// Assumes flag groups and masks A/B arrive on core_clk from the event unit.
// Notes on behaviour
// - Capture mask bits enable four capture irqs
// - Capture mask upper bits read zero
// - Vector A gives top pending id
// - Vector B gives top pending id
// - Vector C gives top capture id
// - Vectors read-only, reset zero, upper zero
//
// Local design decision: the APB slave port.
module eimv_top import eimv_pkg::*; #(
    parameter logic [EIMV_GRP_W*EIMV_VEC_W-1:0] ID_TABLE_A = '0,
    parameter logic [EIMV_GRP_W*EIMV_VEC_W-1:0] ID_TABLE_B = '0,
    parameter logic [EIMV_GRP_W*EIMV_VEC_W-1:0] ID_TABLE_C = '0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [EIMV_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [EIMV_GRP_W-1:0] flag_group_a,
    input wire logic [EIMV_GRP_W-1:0] flag_group_b,
    input wire logic [EIMV_CAP_W-1:0] flag_group_c,
    input wire logic [EIMV_GRP_W-1:0] mask_group_a,
    input wire logic [EIMV_GRP_W-1:0] mask_group_b,
    output logic [EIMV_CAP_W-1:0] capture_irq_enable,
    output logic irq
);
    // ==========================================================
    // State
    typedef struct packed {
        logic [EIMV_CAP_W-1:0] cap_mask;
        logic [EIMV_VEC_W-1:0] vec_a;
        logic [EIMV_VEC_W-1:0] vec_b;
        logic [EIMV_VEC_W-1:0] vec_c;
        logic [EIMV_NGRP-1:0] irq_status;
        logic [EIMV_NGRP-1:0] irq_mask;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
    } eimv_state_s;

    eimv_state_s st_r;
    eimv_state_s st_nxt;
    logic [EIMV_VEC_W-1:0] id_a;
    logic [EIMV_VEC_W-1:0] id_b;
    logic [EIMV_VEC_W-1:0] id_c;
    logic [EIMV_GRP_W-1:0] pend_c;
    logic setup;
    logic wr_ok;
    logic [EIMV_NGRP-1:0] ev;

    // ==========================================================
    // Vector encoders
    assign pend_c = {{(EIMV_GRP_W-EIMV_CAP_W){1'b0}}, flag_group_c & st_r.cap_mask};

    eimv_prio #(.N(EIMV_GRP_W)) u_prio_a (
        .pending(flag_group_a & mask_group_a),
        .id_table(ID_TABLE_A),
        .vector_id(id_a)
    );
    eimv_prio #(.N(EIMV_GRP_W)) u_prio_b (
        .pending(flag_group_b & mask_group_b),
        .id_table(ID_TABLE_B),
        .vector_id(id_b)
    );
    eimv_prio #(.N(EIMV_GRP_W)) u_prio_c (
        .pending(pend_c),
        .id_table(ID_TABLE_C),
        .vector_id(id_c)
    );

    // ==========================================================
    // Next state
    // Answer one cycle after setup; registers read out of the flop copy
    assign setup = psel && !penable;
    assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
    assign ev = {id_c != EIMV_VEC_NONE, id_b != EIMV_VEC_NONE, id_a != EIMV_VEC_NONE};

    always_comb begin
        st_nxt = st_r;
        st_nxt.vec_a = id_a;
        st_nxt.vec_b = id_b;
        st_nxt.vec_c = id_c;
        st_nxt.ready = setup;
        st_nxt.slverr = 1'b0;
        if (wr_ok && paddr == eimv_byte_addr(EIMV_IDX_CAPTURE_IRQ_MASK)) begin
            st_nxt.cap_mask = pwdata[EIMV_CAP_W-1:0];
        end
        if (wr_ok && paddr == eimv_byte_addr(EIMV_IDX_IRQ_MASK)) begin
            st_nxt.irq_mask = pwdata[EIMV_NGRP-1:0];
        end
        // Set beats clear in the same cycle
        if (wr_ok && paddr == eimv_byte_addr(EIMV_IDX_IRQ_STATUS)) begin
            st_nxt.irq_status = (st_r.irq_status & ~pwdata[EIMV_NGRP-1:0]) | ev;
        end else begin
            st_nxt.irq_status = st_r.irq_status | ev;
        end
        st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);
        if (setup) begin
            st_nxt.rdata = EIMV_ZERO_WORD;
            case (paddr)
                eimv_byte_addr(EIMV_IDX_CAPTURE_IRQ_MASK): st_nxt.rdata[EIMV_CAP_W-1:0] = st_r.cap_mask;
                eimv_byte_addr(EIMV_IDX_VECTOR_GROUP_A): st_nxt.rdata[EIMV_VEC_W-1:0] = st_r.vec_a;
                eimv_byte_addr(EIMV_IDX_VECTOR_GROUP_B): st_nxt.rdata[EIMV_VEC_W-1:0] = st_r.vec_b;
                eimv_byte_addr(EIMV_IDX_VECTOR_GROUP_C): st_nxt.rdata[EIMV_VEC_W-1:0] = st_r.vec_c;
                eimv_byte_addr(EIMV_IDX_IRQ_STATUS): st_nxt.rdata[EIMV_NGRP-1:0] = st_r.irq_status;
                eimv_byte_addr(EIMV_IDX_IRQ_MASK): st_nxt.rdata[EIMV_NGRP-1:0] = st_r.irq_mask;
                default: st_nxt.slverr = 1'b1;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.rdata;
    assign pready = st_r.ready;
    assign pslverr = st_r.slverr;
    assign capture_irq_enable = st_r.cap_mask;
    assign irq = st_r.irq;

    // ==========================================================
    // Checks
    a_capmask_write: assert property (@(posedge core_clk) disable iff (!rst_n)
        wr_ok && paddr == eimv_byte_addr(EIMV_IDX_CAPTURE_IRQ_MASK)
        |=> capture_irq_enable == $past(pwdata[EIMV_CAP_W-1:0]))
        else $error("capture mask write lost");
    a_capmask_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(wr_ok && paddr == eimv_byte_addr(EIMV_IDX_CAPTURE_IRQ_MASK)) |=> $stable(capture_irq_enable))
        else $error("capture mask changed without write");
    a_capmask_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
        pready && $past(paddr) == eimv_byte_addr(EIMV_IDX_CAPTURE_IRQ_MASK) |-> prdata[31:EIMV_CAP_W] == '0)
        else $error("capture mask upper bits not zero");
    a_vec_a_track: assert property (@(posedge core_clk) disable iff (!rst_n)
        (flag_group_a & mask_group_a) == '0 |=> st_r.vec_a == EIMV_VEC_NONE)
        else $error("vector A not zero when idle");
    a_vec_b_track: assert property (@(posedge core_clk) disable iff (!rst_n)
        (flag_group_b & mask_group_b) == '0 |=> st_r.vec_b == EIMV_VEC_NONE)
        else $error("vector B not zero when idle");
    a_vec_c_masked: assert property (@(posedge core_clk) disable iff (!rst_n)
        (flag_group_c & capture_irq_enable) == '0 |=> st_r.vec_c == EIMV_VEC_NONE)
        else $error("vector C not zero when masked");
    a_vec_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
        pready && ($past(paddr) == eimv_byte_addr(EIMV_IDX_VECTOR_GROUP_A)
        || $past(paddr) == eimv_byte_addr(EIMV_IDX_VECTOR_GROUP_C)) |-> prdata[31:EIMV_VEC_W] == '0)
        else $error("vector upper bits not zero");
    a_vec_b_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
        pready && $past(paddr) == eimv_byte_addr(EIMV_IDX_VECTOR_GROUP_B) |-> prdata[31:EIMV_VEC_W] == '0)
        else $error("vector B upper bits not zero");
    // Refused accesses must not leak stale read data
    a_slverr_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        pready && pslverr |-> prdata == '0)
        else $error("error response with nonzero data");
    a_ready_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        !psel |=> !pready)
        else $error("ready without a request");
    a_strb_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
        psel && penable && pready && pwrite && !pstrb[0] |=> $stable(capture_irq_enable))
        else $error("write without lane 0 took effect");
    // A clear in the same cycle as an event must lose
    a_status_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        ev != '0 |=> (st_r.irq_status & $past(ev)) == $past(ev))
        else $error("irq status event lost");
    a_irq_masked_off: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_r.irq_mask == '0 && !(wr_ok && paddr == eimv_byte_addr(EIMV_IDX_IRQ_MASK)) |=> !irq)
        else $error("irq while fully masked");
    a_ready_once: assert property (@(posedge core_clk) disable iff (!rst_n)
        psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");
    a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        irq |-> (st_r.irq_status & st_r.irq_mask) != '0)
        else $error("irq without unmasked status");
endmodule : eimv_top
